// ---- hw/wdog_pmon_cfg.svh ----
// Register offsets, bit positions and timing counts of the watchdog and supply monitor
`ifndef WDOG_PMON_CFG_SVH
`define WDOG_PMON_CFG_SVH
`define ADDR_WDCTL      8'hD8
`define ADDR_TIMED      8'hC7
`define ADDR_CLKCTL     8'h8E
`define ADDR_XIE        8'hE8
`define ADDR_XIF        8'h91
`define ADDR_PWRMGMT    8'hC4
`define ADDR_FLASHCTL   8'hD5
`define TA_KEY1         8'hAA
`define TA_KEY2         8'h55
`define TA_WINDOW       2'h3
`define SYSRST_CMD      4'hF
`define B_RESTART       0
`define B_RST_EN        1
`define B_RST_FLAG      2
`define B_IRQ_FLAG      3
`define B_PF_FLAG       4
`define B_PF_IE         5
`define B_POR_FLAG      6
`define B_WD_IE         4
`define B_BG_KEEP       0
`define B_MULT_RATIO    3
`define B_MULT_EN       4
`define B_RATIO_LO      6
`define B_CD_LO         6
`define RATIO_DEFAULT   2'h0
`define CD_DEFAULT      2'h2
`define STARTUP_CYC     17'h10000
`define RST_EXTRA_CYC   10'h200
`define SWRST_CYC       7'h5A
`define TMR_W           37
`define TMR_W_M1        36
`define LOG_MUL4        6'h0F
`define LOG_MUL2        6'h10
`define LOG_DIV1        6'h11
`define LOG_DIV1K       6'h1B
`endif

// ---- hw/wdog_pmon_pkg.sv ----
// Types shared by the watchdog and supply monitor
package wdog_pmon_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
  typedef enum logic [1:0] {ST_POWERUP, ST_RUN, ST_SWRST, ST_WARMUP} rst_state_t;
endpackage

// ---- hw/wdog_pmon.sv ----
// Watchdog timer, supply monitor and system reset sequencer
//
// Overview of operation
// - Power-fail warning with its enable set raises the power-fail interrupt.
// - Power-fail flag sets on every warning entry, stays until software clears it.
// - Supply below reset trip level asserts the internal reset.
// - Power-up holds reset until supply good plus 65,536 oscillator cycles.
// - Power-on reset sets the power-on flag until software clears it.
// - Stop mode with bandgap keep clear powers down the comparators.
// - Default ratio at divide 10b: interrupt at 2^17, reset 512 later.
// - Ratio select sets interrupt timeout; each step multiplies by eight.
// - Reset timeout is interrupt timeout plus 512 system clocks.
// - Any reset returns the ratio select to its default.
// - Writing one to restart begins a full new interval.
// - Watchdog reset only when reset enable set; else periodic interrupts.
// - Interrupt flag sets at interrupt timeout; reset flag after watchdog reset.
// - Watchdog interrupt reaches the core only with its enable set.
// - Watchdog timeouts count system clocks.
// - Start-up counter counts 65,536 crystal cycles before crystal is used.
// - Start-up timing also runs when the multiplier enable is set.
// - Watchdog interrupt timeout wakes the device from idle only with its interrupt enable set.
// - Software reset command holds reset about 90 clocks, reset pin high.
// - Protected bits change only within three cycles after AAh then 55h.
// - Watchdog control and flag bits sit at D8h; ratio select at 8Eh, interrupt enable at E8h.
`timescale 1ns/1ps
`include "wdog_pmon_cfg.svh"

module wdog_pmon (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire wdog_pmon_pkg::reg_req_t req,
  output logic [7:0]                 rdata,
  input  wire logic                  powerfail_warn_level,
  input  wire logic                  reset_trip_level,
  input  wire logic                  stop_mode,
  input  wire logic                  idle_mode,
  input  wire logic                  osc_tick,
  output logic                       core_reset,
  output logic                       rst_pin_o,
  output logic                       rst_pin_oe,
  output logic                       powerfail_irq,
  output logic                       wdog_irq,
  output logic                       idle_wake,
  output logic                       bandgap_on,
  output logic                       crystal_ready
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {osc_tick, reset_trip_level, powerfail_warn_level};
      sync2_r <= sync1_r;
    end
  end
  logic pfw_s;
  logic trip_s;
  logic tick_s;
  assign pfw_s  = sync2_r[0];
  assign trip_s = sync2_r[1];
  assign tick_s = sync2_r[2];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [6:0] wdctl_r;
  logic [1:0] ratio_r;
  logic [1:0] cd_r;
  logic       wd_ie_r;
  logic       bg_keep_r;
  logic       mult_en_r;
  logic       mult_ratio_r;
  logic [1:0] ta_win_r;
  logic       ta_armed_r;
  logic [1:0] ta_arm_cnt_r;
  logic       pfw_d_r;
  logic       int_hit;
  logic       rst_hit;
  logic       sys_reset;
  logic       wd_rst_evt;
  logic       por_evt;
  wdog_pmon_pkg::rst_state_t st_r;

  logic ta_open;
  logic wr_wd;
  logic pf_rise;
  assign ta_open = (ta_win_r != 2'h0);
  assign wr_wd   = req.wr && (req.addr == `ADDR_WDCTL);
  assign pf_rise = pfw_s && !pfw_d_r;
  assign sys_reset = (st_r != wdog_pmon_pkg::ST_RUN);

  // ----------------------------------------------------------------
  // Timed access unlock
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ta_armed_r   <= 1'b0;
      ta_arm_cnt_r <= 2'h0;
      ta_win_r     <= 2'h0;
    end else if (req.wr && req.addr == `ADDR_TIMED && req.wdata == `TA_KEY1) begin
      ta_armed_r   <= 1'b1;
      ta_arm_cnt_r <= `TA_WINDOW;
      ta_win_r     <= 2'h0;
    // Second key only counts while the first is still armed
    end else if (req.wr && req.addr == `ADDR_TIMED && req.wdata == `TA_KEY2
                 && ta_armed_r) begin
      ta_armed_r <= 1'b0;
      ta_win_r   <= `TA_WINDOW;
    end else begin
      ta_arm_cnt_r <= (ta_arm_cnt_r != 2'h0) ? ta_arm_cnt_r - 2'h1 : 2'h0;
      ta_armed_r   <= ta_armed_r && (ta_arm_cnt_r > 2'h1);
      ta_win_r     <= ta_open ? ta_win_r - 2'h1 : 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wdctl_r <= 7'h40;
    end else begin
      if (wr_wd) begin
        wdctl_r[`B_PF_IE] <= req.wdata[`B_PF_IE];
        wdctl_r[`B_RST_FLAG] <= req.wdata[`B_RST_FLAG];
        if (!req.wdata[`B_PF_FLAG]) wdctl_r[`B_PF_FLAG] <= 1'b0;
        if (ta_open) begin
          wdctl_r[`B_RST_EN]   <= req.wdata[`B_RST_EN];
          wdctl_r[`B_IRQ_FLAG] <= req.wdata[`B_IRQ_FLAG];
          wdctl_r[`B_POR_FLAG] <= req.wdata[`B_POR_FLAG];
        end
      end
      wdctl_r[`B_RESTART] <= 1'b0;
      // Hardware set beats a same-cycle software clear
      if (pf_rise) wdctl_r[`B_PF_FLAG] <= 1'b1;
      if (int_hit) wdctl_r[`B_IRQ_FLAG] <= 1'b1;
      if (wd_rst_evt) wdctl_r[`B_RST_FLAG] <= 1'b1;
      if (wd_rst_evt) wdctl_r[`B_RST_EN] <= 1'b0;
      if (por_evt) wdctl_r[`B_POR_FLAG] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Clock, interrupt enable and flag registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n || sys_reset) begin
      ratio_r      <= `RATIO_DEFAULT;
      cd_r         <= `CD_DEFAULT;
      mult_en_r    <= 1'b0;
      mult_ratio_r <= 1'b0;
    end else if (req.wr && req.addr == `ADDR_CLKCTL) begin
      ratio_r <= req.wdata[`B_RATIO_LO +: 2];
    end else if (req.wr && req.addr == `ADDR_PWRMGMT) begin
      cd_r      <= req.wdata[`B_CD_LO +: 2];
      mult_en_r <= req.wdata[`B_MULT_EN];
      if (!mult_en_r) mult_ratio_r <= req.wdata[`B_MULT_RATIO];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wd_ie_r   <= 1'b0;
      bg_keep_r <= 1'b0;
    end else begin
      if (req.wr && req.addr == `ADDR_XIE) wd_ie_r <= req.wdata[`B_WD_IE];
      if (req.wr && req.addr == `ADDR_XIF && ta_open)
        bg_keep_r <= req.wdata[`B_BG_KEEP];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) pfw_d_r <= 1'b0;
    else pfw_d_r <= pfw_s;
  end

  // ----------------------------------------------------------------
  // Watchdog counter in system clocks
  // ----------------------------------------------------------------
  logic [`TMR_W-1:0] wd_cnt_r;
  logic [`TMR_W-1:0] int_limit;
  logic [`TMR_W-1:0] rst_limit;
  logic [5:0]        base_log;
  logic [5:0]        sh;
  logic              restart;

  // Base exponent follows the divide setting; each ratio step adds three
  always_comb begin
    if (cd_r == 2'h0) base_log = mult_ratio_r ? `LOG_MUL4 : `LOG_MUL2;
    else if (cd_r == 2'h3) base_log = `LOG_DIV1K;
    else base_log = `LOG_DIV1;
    sh = base_log + {3'h0, ratio_r, 1'b0} + {4'h0, ratio_r};
  end
  assign int_limit = {{`TMR_W_M1{1'b0}}, 1'b1} << sh;
  assign rst_limit = int_limit + {{(`TMR_W-10){1'b0}}, `RST_EXTRA_CYC};
  assign restart = wr_wd && ta_open && req.wdata[`B_RESTART];
  assign int_hit = !sys_reset && (wd_cnt_r == int_limit - 1'b1);
  assign rst_hit = !sys_reset && (wd_cnt_r == rst_limit - 1'b1);
  assign wd_rst_evt = rst_hit && wdctl_r[`B_RST_EN];

  always_ff @(posedge ref_clk) begin
    if (!rst_n || sys_reset || restart) wd_cnt_r <= '0;
    else if (wdctl_r[`B_RST_EN] ? rst_hit : int_hit)
      wd_cnt_r <= '0;
    else wd_cnt_r <= wd_cnt_r + 1'b1;
  end

  // ----------------------------------------------------------------
  // Reset sequencer and crystal start-up counter
  // ----------------------------------------------------------------
  logic [16:0] su_cnt_r;
  logic        stop_d_r;
  logic        mult_d_r;
  logic        xtal_ok_r;
  logic        su_done;
  assign su_done = (su_cnt_r == `STARTUP_CYC);
  logic swrst_cmd;
  // Only the full command nibble inside the unlock window starts a reset
  assign swrst_cmd = req.wr && req.addr == `ADDR_FLASHCTL && ta_open
                     && req.wdata[3:0] == `SYSRST_CMD;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r      <= wdog_pmon_pkg::ST_POWERUP;
      su_cnt_r  <= '0;
      stop_d_r  <= 1'b0;
      mult_d_r  <= 1'b0;
      xtal_ok_r <= 1'b0;
      por_evt   <= 1'b0;
    end else begin
      stop_d_r <= stop_mode;
      mult_d_r <= mult_en_r;
      por_evt  <= 1'b0;
      if ((stop_d_r && !stop_mode) || (mult_en_r && !mult_d_r)) begin
        su_cnt_r  <= '0;
        xtal_ok_r <= 1'b0;
      end else if (tick_s && !su_done) begin
        su_cnt_r <= su_cnt_r + 17'h1;
      end else if (su_done) begin
        xtal_ok_r <= 1'b1;
      end
      if (!trip_s) begin
        st_r     <= wdog_pmon_pkg::ST_POWERUP;
        su_cnt_r <= '0;
      end else case (st_r)
        wdog_pmon_pkg::ST_POWERUP: begin
          if (su_done) begin
            st_r    <= wdog_pmon_pkg::ST_RUN;
            por_evt <= 1'b1;
          end
        end
        wdog_pmon_pkg::ST_RUN: begin
          if (swrst_cmd) begin
            st_r     <= wdog_pmon_pkg::ST_SWRST;
            su_cnt_r <= '0;
          end else if (wd_rst_evt) begin
            st_r <= xtal_ok_r ? wdog_pmon_pkg::ST_SWRST
                              : wdog_pmon_pkg::ST_WARMUP;
            su_cnt_r <= xtal_ok_r ? 17'h0 : su_cnt_r;
          end
        end
        wdog_pmon_pkg::ST_SWRST: begin
          su_cnt_r <= su_cnt_r + 17'h1;
          if (su_cnt_r == {10'h0, `SWRST_CYC} - 17'h1) begin
            st_r     <= wdog_pmon_pkg::ST_RUN;
            su_cnt_r <= `STARTUP_CYC;
          end
        end
        wdog_pmon_pkg::ST_WARMUP: begin
          if (su_done) st_r <= wdog_pmon_pkg::ST_RUN;
        end
        default: st_r <= wdog_pmon_pkg::ST_POWERUP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign core_reset    = sys_reset;
  assign rst_pin_o     = (st_r == wdog_pmon_pkg::ST_SWRST);
  assign rst_pin_oe    = 1'b1;
  assign powerfail_irq = wdctl_r[`B_PF_IE] && wdctl_r[`B_PF_FLAG];
  assign wdog_irq      = wd_ie_r && wdctl_r[`B_IRQ_FLAG];
  assign idle_wake     = idle_mode && wdog_irq;
  assign bandgap_on    = !stop_mode || bg_keep_r;
  assign crystal_ready = xtal_ok_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) rdata <= 8'h00;
    else if (!req.rd) rdata <= 8'h00;
    else case (req.addr)
      `ADDR_WDCTL:   rdata <= {1'b0, wdctl_r};
      `ADDR_CLKCTL:  rdata <= {ratio_r, 6'h00};
      `ADDR_PWRMGMT: rdata <= {cd_r, 1'b0, mult_en_r, mult_ratio_r, 3'h0};
      `ADDR_XIE:     rdata <= {3'h0, wd_ie_r, 4'h0};
      `ADDR_XIF:     rdata <= {7'h00, bg_keep_r};
      default:       rdata <= 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  pf_flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pf_rise |=> wdctl_r[`B_PF_FLAG]) else $error("power-fail flag not set");
  pf_irq_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pf_rise && wdctl_r[`B_PF_IE] && !wr_wd |=> powerfail_irq)
    else $error("pf irq missing");
  trip_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !trip_s |=> core_reset) else $error("no reset below trip");
  por_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    por_evt |=> wdctl_r[`B_POR_FLAG]) else $error("por flag not set");
  ratio_default_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sys_reset |=> ratio_r == `RATIO_DEFAULT) else $error("ratio not defaulted");
  wd_irq_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    int_hit |=> wdctl_r[`B_IRQ_FLAG]) else $error("irq flag not set");
  wd_irq_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    int_hit && wd_ie_r && !(req.wr && req.addr == `ADDR_XIE) |=> wdog_irq)
    else $error("wdog irq missing");
  wd_rst_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wd_rst_evt |=> core_reset && wdctl_r[`B_RST_FLAG] && !wdctl_r[`B_RST_EN])
    else $error("watchdog reset not taken");
  restart_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    restart |=> wd_cnt_r == '0) else $error("restart ignored");
  bandgap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stop_mode && !bg_keep_r |-> !bandgap_on) else $error("bandgap left on");

  por_seen_c:  cover property (@(posedge ref_clk) por_evt);
  wd_int_c:    cover property (@(posedge ref_clk) int_hit);
  wd_rst_c:    cover property (@(posedge ref_clk) wd_rst_evt);
  sw_rst_c:    cover property (@(posedge ref_clk) swrst_cmd);
  pf_irq_c:    cover property (@(posedge ref_clk) powerfail_irq);

endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the watchdog, supply monitor and reset sequencer
`timescale 1ns/1ps
`include "wdog_pmon_cfg.svh"
module tb_top;
  logic                    ref_clk = 1'b0;
  logic                    rst_n = 1'b0;
  wdog_pmon_pkg::reg_req_t req = '0;
  logic [7:0]              rdata;
  logic                    powerfail_warn_level = 1'b0;
  logic                    reset_trip_level = 1'b0;
  logic                    stop_mode = 1'b0;
  logic                    idle_mode = 1'b0;
  logic                    osc_tick = 1'b0;
  logic                    core_reset, rst_pin_o, rst_pin_oe, powerfail_irq;
  logic                    wdog_irq, idle_wake, bandgap_on, crystal_ready;
  logic [7:0]              v;
  int                      cyc = 0, hit = 0, t0 = 0;
  int                      mismatches = 0, checked = 0;

  wdog_pmon wdog_pmon_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .powerfail_warn_level(powerfail_warn_level), .reset_trip_level(reset_trip_level),
    .stop_mode(stop_mode), .idle_mode(idle_mode), .osc_tick(osc_tick),
    .core_reset(core_reset), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
    .powerfail_irq(powerfail_irq), .wdog_irq(wdog_irq), .idle_wake(idle_wake),
    .bandgap_on(bandgap_on), .crystal_ready(crystal_ready)
  );

  always #25 ref_clk = ~ref_clk;
  // Oscillator ticks every clock, keeping the start-up wait at 65,536 clocks
  always @(posedge ref_clk) osc_tick <= 1'b1;
  always @(posedge ref_clk) cyc <= cyc + 1;

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  // Write leaves its strobe up so writes can run back to back; end with idle or rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
  endtask
  task automatic idle();
    req <= '0;
    @(posedge ref_clk);
  endtask
  task automatic tw(input logic [7:0] a, input logic [7:0] d);
    wr(`ADDR_TIMED, `TA_KEY1);
    wr(`ADDR_TIMED, `TA_KEY2);
    wr(a, d);
    idle();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req <= '0;
    @(negedge ref_clk);
    d = rdata;
    @(posedge ref_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi, input int g);
    checked++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // Sampled on the falling edge, returns just after a rising edge
  task automatic wait_lvl(ref logic s, input logic lvl, input int lim);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (s !== lvl && n < lim) begin
      n++;
      @(negedge ref_clk);
    end
    hit = cyc;
    @(posedge ref_clk);
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog against a hung design
  // ----------------------------------------
  // Power-up and one short watchdog interval dominate the run time
  initial begin
    #(50.0 * 115000);
    mismatches++;
    test_done();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    hold(12);
    rst_n <= 1'b1;
    hold(1);
    rd(`ADDR_WDCTL, v); chk("ctl reset value", 8'h40, v);
    rd(8'h00, v); chk("unmapped read", 8'h00, v);
    rd(`ADDR_CLKCTL, v); chk("ratio default", `RATIO_DEFAULT, v[7:6]);
    rd(`ADDR_PWRMGMT, v); chk("divide default", `CD_DEFAULT, v[7:6]);
    hold(20);
    chk("reset while supply low", 1'b1, core_reset);
    reset_trip_level <= 1'b1;
    t0 = cyc;
    wait_lvl(core_reset, 1'b0, 70000);
    rng("power-up delay", 65530, 65560, hit - t0);
    chk("crystal ready", 1'b1, crystal_ready);
    // Protected bits without the unlock sequence
    wr(`ADDR_WDCTL, 8'h03); rd(`ADDR_WDCTL, v); chk("locked ctl", 8'h40, v);
    tw(`ADDR_WDCTL, 8'h00); rd(`ADDR_WDCTL, v); chk("unlocked ctl", 8'h00, v);
    // Power-fail warning with and without its enable
    wr(`ADDR_WDCTL, 8'h20);
    powerfail_warn_level <= 1'b1;
    idle(); hold(5);
    chk("powerfail irq", 1'b1, powerfail_irq);
    powerfail_warn_level <= 1'b0;
    hold(5);
    rd(`ADDR_WDCTL, v); chk("powerfail flag held", 8'h30, v);
    wr(`ADDR_WDCTL, 8'h00); rd(`ADDR_WDCTL, v); chk("flag cleared", 8'h00, v);
    powerfail_warn_level <= 1'b1;
    hold(5);
    chk("powerfail irq masked", 1'b0, powerfail_irq);
    rd(`ADDR_WDCTL, v); chk("flag without enable", 8'h10, v);
    powerfail_warn_level <= 1'b0;
    wr(`ADDR_WDCTL, 8'h00); idle();
    // Bandgap power in stop mode
    stop_mode <= 1'b1;
    hold(3);
    chk("bandgap off in stop", 1'b0, bandgap_on);
    tw(`ADDR_XIF, 8'h01); hold(2);
    chk("bandgap kept in stop", 1'b1, bandgap_on);
    stop_mode <= 1'b0;
    // Software reset returns the ratio select to default
    wr(`ADDR_CLKCTL, 8'hC0); rd(`ADDR_CLKCTL, v); chk("ratio written", 2'h3, v[7:6]);
    tw(`ADDR_FLASHCTL, {4'h0, `SYSRST_CMD});
    wait_lvl(rst_pin_o, 1'b1, 10);
    t0 = hit;
    chk("core reset in sw reset", 1'b1, core_reset);
    wait_lvl(rst_pin_o, 1'b0, 200);
    rng("sw reset length", 88, 92, hit - t0);
    chk("pin driven low", 1'b1, rst_pin_oe);
    hold(4);
    chk("core running", 1'b0, core_reset);
    rd(`ADDR_CLKCTL, v); chk("ratio after reset", `RATIO_DEFAULT, v[7:6]);
    // Watchdog at the shortest base 2^15: restart, restart again, reset follows
    wr(`ADDR_PWRMGMT, 8'h08); rd(`ADDR_PWRMGMT, v); chk("fast divide", 8'h08, v);
    wr(`ADDR_XIE, 8'h10);
    idle_mode <= 1'b1;
    tw(`ADDR_WDCTL, 8'h03);
    hold(1000);
    wr(`ADDR_TIMED, `TA_KEY1);
    wr(`ADDR_TIMED, `TA_KEY2);
    wr(`ADDR_WDCTL, 8'h03);
    t0 = cyc;
    idle();
    wait_lvl(wdog_irq, 1'b1, 40000);
    rng("irq timeout", 32760, 32780, hit - t0);
    t0 = hit;
    chk("idle wake", 1'b1, idle_wake);
    rd(`ADDR_WDCTL, v); chk("irq flag", 1'b1, v[`B_IRQ_FLAG]);
    wr(`ADDR_XIE, 8'h00); idle();
    chk("irq masked", 1'b0, wdog_irq);
    wr(`ADDR_XIE, 8'h10); idle();
    wait_lvl(core_reset, 1'b1, 600);
    rng("reset after irq", 505, 520, hit - t0);
    wait_lvl(core_reset, 1'b0, 300);
    chk("resume after wdog reset", 1'b0, core_reset);
    rd(`ADDR_WDCTL, v); chk("reset flag", 8'h04, v & 8'h06);
    idle_mode <= 1'b0;
    // Multiplier enable restarts the start-up count
    wr(`ADDR_PWRMGMT, 8'h90); idle(); hold(4);
    chk("start-up rerun", 1'b0, crystal_ready);
    // Brown-out
    reset_trip_level <= 1'b0;
    hold(5);
    chk("brown-out reset", 1'b1, core_reset);
    test_done();
  end
endmodule
